// file: logic/sfp_pkg.sv
package sfp_pkg;

  // Clock rate and the two self-timed cycle lengths
  localparam int unsigned CLOCK_MHZ = 40;
  localparam int unsigned DDR_PROGRAM_TIME_US = 800;
  localparam int unsigned SMALL_BLOCK_WIPE_TIME_US = 45000;
  localparam int unsigned DDR_PROGRAM_CYCLES = DDR_PROGRAM_TIME_US * CLOCK_MHZ;
  localparam int unsigned SMALL_BLOCK_WIPE_CYCLES = SMALL_BLOCK_WIPE_TIME_US * CLOCK_MHZ;

  // Instruction codes
  localparam logic [7:0] OP_WRITE_UNLOCK = 8'h06;
  localparam logic [7:0] OP_FOUR_WIRE_ENTRY = 8'h38;
  localparam logic [7:0] OP_QUAD_PAGE_WRITE_4B = 8'h34;
  localparam logic [7:0] OP_DOUBLE_RATE_PROGRAM = 8'hD2;
  localparam logic [7:0] OP_BLOCK4K_WIPE = 8'h20;

  // Geometry and field positions
  localparam int unsigned PAGE_BYTES = 256;
  localparam int unsigned CMD_BITS = 8;
  localparam int unsigned SHORT_ADDR_BITS = 24;
  localparam int unsigned LONG_ADDR_BITS = 32;
  localparam int unsigned SECTOR_BITS = 12;
  localparam int unsigned MEM_ADDR_BITS = 26;
  localparam int unsigned PROT_UNIT_BITS = 16;
  localparam int unsigned PROT_ALL_LEVEL = 11;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;

  // Reset values
  localparam logic [5:0] PIN_RESET = 6'h10;
  localparam int unsigned FIFO_DEPTH_DEFAULT = 4;

  typedef enum logic [2:0] {
    FR_CMD  = 3'b000,
    FR_ADDR = 3'b001,
    FR_DATA = 3'b010,
    FR_END  = 3'b011,
    FR_SKIP = 3'b100
  } sfp_frame_type;

  typedef enum logic [1:0] {
    CY_IDLE  = 2'b00,
    CY_DRAIN = 2'b01,
    CY_WAIT  = 2'b10
  } sfp_cycle_type;

  typedef enum logic {
    ARR_PROGRAM = 1'b0,
    ARR_WIPE    = 1'b1
  } sfp_array_op_type;

  typedef struct packed {
    sfp_array_op_type op;
    logic [31:0] addr;
    logic [7:0] data;
  } sfp_array_word_type;

  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic [3:0] io;
  } sfp_pins_type;

  typedef struct packed {
    logic protect_invert;
    logic top_bottom_select;
    logic [3:0] protect_level;
  } sfp_protect_type;

  localparam int unsigned ARRAY_WORD_BITS = $bits(sfp_array_word_type);

endpackage

// file: logic/sfp_cmd_seq.sv
`timescale 1ns/1ps

module sfp_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned PW = $clog2(DEPTH);

  // Power-of-two depth keeps the pointers free-running
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("fifo depth must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic [PW:0] count_reg;
  logic push;
  logic pop;

  assign in_ready = (count_reg != (PW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data = mem_reg[rd_ptr_reg];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Storage has no reset; only pointers and fill level carry state
  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      count_reg <= count_reg + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule

module sfp_cmd_seq
  #(
  parameter int unsigned PROGRAM_CYCLES = sfp_pkg::DDR_PROGRAM_CYCLES,
  parameter int unsigned WIPE_CYCLES = sfp_pkg::SMALL_BLOCK_WIPE_CYCLES,
  parameter int unsigned FIFO_DEPTH = sfp_pkg::FIFO_DEPTH_DEFAULT
) (
  input wire logic CLOCK,
  input wire logic RESET_N,
  input wire logic SCLK,
  input wire logic CS_N,
  input wire logic IO_LANE_0,
  input wire logic IO_LANE_1,
  input wire logic IO_LANE_2,
  input wire logic IO_LANE_3,
  input wire logic QUAD_PINS_ON,
  input wire logic FOUR_BYTE_MODE,
  input wire logic [7:0] EXT_ADDR,
  input wire sfp_pkg::sfp_protect_type PROTECT,
  output sfp_pkg::sfp_array_word_type ARRAY_WORD,
  output logic ARRAY_VALID,
  input wire logic ARRAY_READY,
  output logic BUSY_FLAG,
  output logic WRITE_LATCH_FLAG,
  output logic FOUR_WIRE_CMD_MODE
);
  import sfp_pkg::*;

  if (PROGRAM_CYCLES < 1 || WIPE_CYCLES < 1) begin : g_bad_cycles
    $error("cycle counts must be at least one");
  end

  // Next bits of a shift register, one or four at a time
  function automatic logic [31:0] shift_in(logic [31:0] sr, logic [3:0] nib, logic wide);
    return wide ? {sr[27:0], nib} : {sr[30:0], nib[0]};
  endfunction

  // Block protection: power-of-two region from top or bottom, optionally inverted
  function automatic logic prot_hit(logic [31:0] a, sfp_protect_type p);
    logic [MEM_ADDR_BITS:0] size;
    logic [MEM_ADDR_BITS:0] off;
    logic hit;
    size = (MEM_ADDR_BITS+1)'(1) << (PROT_UNIT_BITS - 1 + 32'(p.protect_level));
    off = {1'b0, a[MEM_ADDR_BITS-1:0]};
    if (p.protect_level == 4'h0) begin
      hit = 1'b0;
    end else if (32'(p.protect_level) >= PROT_ALL_LEVEL) begin
      hit = 1'b1;
    end else if (p.top_bottom_select) begin
      hit = (off < size);
    end else begin
      hit = (off >= ((MEM_ADDR_BITS+1)'(1) << MEM_ADDR_BITS) - size);
    end
    return hit ^ p.protect_invert;
  endfunction

  logic rst_meta_reg;
  logic rst_sync_reg;
  logic rst_n;

  // Reset release through two flops
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  assign rst_n = rst_sync_reg;

  logic [5:0] pin_s1_reg;
  logic [5:0] pin_s2_reg;
  logic [5:0] pin_s3_reg;
  logic [5:0] pin_filt_reg;
  logic [5:0] pin_prev_reg;
  sfp_pins_type pins;
  sfp_pins_type prev;

  // Pin synchronisers; a change counts once stages two and three agree
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_reg <= PIN_RESET;
      pin_s2_reg <= PIN_RESET;
      pin_s3_reg <= PIN_RESET;
      pin_filt_reg <= PIN_RESET;
      pin_prev_reg <= PIN_RESET;
    end else begin
      pin_s1_reg <= {SCLK, CS_N, IO_LANE_3, IO_LANE_2, IO_LANE_1, IO_LANE_0};
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
      for (int i = 0; i < 6; i++) begin
        if (pin_s2_reg[i] == pin_s3_reg[i]) begin
          pin_filt_reg[i] <= pin_s3_reg[i];
        end
      end
      pin_prev_reg <= pin_filt_reg;
    end
  end
  assign pins = pin_filt_reg;
  assign prev = pin_prev_reg;

  sfp_frame_type frame_reg;
  sfp_cycle_type cycle_reg;
  logic [7:0] opcode_reg;
  logic [31:0] sr_reg;
  logic [5:0] bit_cnt_reg;
  logic [5:0] addr_bits_reg;
  logic [31:0] addr_reg;
  logic [7:0] col_reg;
  logic got_data_reg;
  logic [7:0] page_mem [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] page_valid_reg;
  logic busy_reg;
  logic latch_reg;
  logic four_wire_reg;

  logic cs_fall;
  logic cs_rise;
  logic sclk_rise;
  logic sclk_fall;
  logic ddr_phase;
  logic ddr_rise_reg;
  logic wide;
  logic shift_edge;
  logic [5:0] step;
  logic [5:0] cnt_next;
  logic [31:0] sr_next;
  logic [31:0] addr_full;
  logic cmd_ok;
  logic unlock_go;
  logic mode_go;
  logic prog_go;
  logic wipe_go;

  // Edge detection on the filtered pins
  assign cs_fall = ~pins.cs_n & prev.cs_n;
  assign cs_rise = pins.cs_n & ~prev.cs_n;
  assign sclk_rise = pins.sclk & ~prev.sclk & ~pins.cs_n;
  assign sclk_fall = ~pins.sclk & prev.sclk & ~pins.cs_n;

  // Lane width and edge choice per phase
  assign ddr_phase = (opcode_reg == OP_DOUBLE_RATE_PROGRAM) && (frame_reg != FR_CMD);
  assign wide = four_wire_reg
      || ((opcode_reg == OP_QUAD_PAGE_WRITE_4B) && (frame_reg != FR_CMD));
  assign shift_edge = sclk_rise | (ddr_phase & sclk_fall & ddr_rise_reg);

  // A fall counts only after a double-rate rise, so the fall closing
  // the single-rate opcode is never taken as an address bit
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      ddr_rise_reg <= 1'b0;
    end else if (sclk_rise) begin
      ddr_rise_reg <= ddr_phase;
    end else if (sclk_fall || cs_fall) begin
      ddr_rise_reg <= 1'b0;
    end
  end
  assign step = wide ? 6'h04 : 6'h01;
  assign cnt_next = bit_cnt_reg + step;
  assign sr_next = shift_in(sr_reg, pins.io, wide);

  // Short address borrows its top byte from the extended address
  assign addr_full = (addr_bits_reg == 6'(LONG_ADDR_BITS))
      ? sr_next : {EXT_ADDR, sr_next[23:0]};

  // Acceptance of a program or erase opcode at decode
  always_comb begin
    cmd_ok = latch_reg && !busy_reg;
    if (sr_next[7:0] == OP_QUAD_PAGE_WRITE_4B) begin
      cmd_ok = cmd_ok && QUAD_PINS_ON && !four_wire_reg;
    end
  end

  // Actions taken only when select rises at an exact boundary
  assign unlock_go = cs_rise && frame_reg == FR_END && opcode_reg == OP_WRITE_UNLOCK;
  assign mode_go = cs_rise && frame_reg == FR_END && opcode_reg == OP_FOUR_WIRE_ENTRY;
  assign prog_go = cs_rise && frame_reg == FR_DATA && bit_cnt_reg == 6'h00
      && got_data_reg;
  assign wipe_go = cs_rise && frame_reg == FR_END && opcode_reg == OP_BLOCK4K_WIPE;

  // Frame decoder; select low framing is trusted from the host
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      frame_reg <= FR_SKIP;
      opcode_reg <= 8'h00;
      sr_reg <= 32'h0000_0000;
      bit_cnt_reg <= 6'h00;
      addr_bits_reg <= 6'(SHORT_ADDR_BITS);
      addr_reg <= 32'h0000_0000;
      col_reg <= 8'h00;
      got_data_reg <= 1'b0;
    end else if (cs_fall) begin
      frame_reg <= FR_CMD;
      opcode_reg <= 8'h00;
      bit_cnt_reg <= 6'h00;
      got_data_reg <= 1'b0;
    end else if (shift_edge) begin
      sr_reg <= sr_next;
      bit_cnt_reg <= cnt_next;
      case (frame_reg)
        FR_CMD: begin
          if (cnt_next == 6'(CMD_BITS)) begin
            opcode_reg <= sr_next[7:0];
            bit_cnt_reg <= 6'h00;
            case (sr_next[7:0])
              OP_QUAD_PAGE_WRITE_4B, OP_DOUBLE_RATE_PROGRAM, OP_BLOCK4K_WIPE: begin
                frame_reg <= cmd_ok ? FR_ADDR : FR_SKIP;
                addr_bits_reg <= (sr_next[7:0] == OP_QUAD_PAGE_WRITE_4B || FOUR_BYTE_MODE)
                    ? 6'(LONG_ADDR_BITS) : 6'(SHORT_ADDR_BITS);
              end
              OP_WRITE_UNLOCK, OP_FOUR_WIRE_ENTRY: begin
                frame_reg <= FR_END;
              end
              default: begin
                frame_reg <= FR_SKIP;
              end
            endcase
          end
        end
        FR_ADDR: begin
          if (cnt_next == addr_bits_reg) begin
            bit_cnt_reg <= 6'h00;
            addr_reg <= addr_full;
            col_reg <= addr_full[7:0];
            if (prot_hit(addr_full, PROTECT)) begin
              frame_reg <= FR_SKIP;
            end else if (opcode_reg == OP_BLOCK4K_WIPE) begin
              frame_reg <= FR_END;
            end else begin
              frame_reg <= FR_DATA;
            end
          end
        end
        FR_DATA: begin
          if (cnt_next == 6'(CMD_BITS)) begin
            bit_cnt_reg <= 6'h00;
            col_reg <= col_reg + 8'h01;
            got_data_reg <= 1'b1;
          end
        end
        FR_END: begin
          frame_reg <= FR_SKIP;
        end
        default: begin
          frame_reg <= FR_SKIP;
        end
      endcase
    end
  end

  // Page buffer: later bytes overwrite earlier ones at the same column
  always_ff @(posedge CLOCK) begin
    if (shift_edge && frame_reg == FR_DATA && cnt_next == 6'(CMD_BITS)) begin
      page_mem[col_reg] <= sr_next[7:0];
    end
  end

  logic [7:0] ro_idx_reg;
  logic [31:0] timer_reg;
  sfp_array_op_type cy_op_reg;
  logic push_valid;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic out_valid_reg;
  sfp_array_word_type push_word;

  // Column valid bits; an opcode decoded with the latch set and not busy clears them (quad write only with quad pins on, four-wire off), never one mid-drain
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      page_valid_reg <= '0;
    end else if (shift_edge && frame_reg == FR_CMD && cnt_next == 6'(CMD_BITS) && cmd_ok) begin
      page_valid_reg <= '0;
    end else if (shift_edge && frame_reg == FR_DATA && cnt_next == 6'(CMD_BITS)) begin
      page_valid_reg[col_reg] <= 1'b1;
    end
  end

  // Word offered to the array during the drain
  always_comb begin
    push_word.op = cy_op_reg;
    if (cy_op_reg == ARR_WIPE) begin
      push_word.addr = {addr_reg[31:SECTOR_BITS], 12'h000};
      push_word.data = ERASED_BYTE;
      push_valid = (cycle_reg == CY_DRAIN);
    end else begin
      push_word.addr = {addr_reg[31:8], ro_idx_reg};
      push_word.data = page_mem[ro_idx_reg];
      push_valid = (cycle_reg == CY_DRAIN) && page_valid_reg[ro_idx_reg];
    end
  end

  // Self-timed cycle: drain to the array, then run out the timer
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      cycle_reg <= CY_IDLE;
      cy_op_reg <= ARR_PROGRAM;
      ro_idx_reg <= 8'h00;
      timer_reg <= 32'h0000_0000;
      busy_reg <= 1'b0;
    end else begin
      if (timer_reg != 32'h0000_0000) begin
        timer_reg <= timer_reg - 32'h0000_0001;
      end
      case (cycle_reg)
        CY_IDLE: begin
          ro_idx_reg <= 8'h00;
          if (prog_go || wipe_go) begin
            cycle_reg <= CY_DRAIN;
            busy_reg <= 1'b1;
            cy_op_reg <= wipe_go ? ARR_WIPE : ARR_PROGRAM;
            timer_reg <= wipe_go ? 32'(WIPE_CYCLES - 1) : 32'(PROGRAM_CYCLES - 1);
          end
        end
        CY_DRAIN: begin
          // Array back-pressure stalls the walk through the page
          if (!push_valid || fifo_in_ready) begin
            ro_idx_reg <= ro_idx_reg + 8'h01;
            if (cy_op_reg == ARR_WIPE || ro_idx_reg == 8'hFF) begin
              cycle_reg <= CY_WAIT;
            end
          end
        end
        CY_WAIT: begin
          // Busy also covers words still queued for the array
          if (timer_reg == 32'h0000_0000 && !fifo_out_valid && !out_valid_reg) begin
            cycle_reg <= CY_IDLE;
            busy_reg <= 1'b0;
          end
        end
        default: begin
          cycle_reg <= CY_IDLE;
          busy_reg <= 1'b0;
        end
      endcase
    end
  end

  // Write latch: set by unlock, cleared as a cycle starts, well before its end
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      latch_reg <= 1'b0;
    end else if (unlock_go) begin
      latch_reg <= 1'b1;
    end else if (prog_go || wipe_go) begin
      latch_reg <= 1'b0;
    end
  end

  // Four-wire command mode is left only by reset here
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      four_wire_reg <= 1'b0;
    end else if (mode_go) begin
      four_wire_reg <= 1'b1;
    end
  end

  logic [ARRAY_WORD_BITS-1:0] fifo_out_data;
  logic fifo_out_ready;
  sfp_array_word_type out_word_reg;

  sfp_fifo #(
    .WIDTH(ARRAY_WORD_BITS),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(CLOCK),
    .rst_n(rst_n),
    .in_valid(push_valid),
    .in_ready(fifo_in_ready),
    .in_data(push_word),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  // Output stage keeps the array port on flops
  assign fifo_out_ready = ~out_valid_reg | ARRAY_READY;
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      out_valid_reg <= 1'b0;
      out_word_reg <= '0;
    end else if (fifo_out_ready) begin
      out_valid_reg <= fifo_out_valid;
      out_word_reg <= fifo_out_data;
    end
  end

  assign ARRAY_VALID = out_valid_reg;
  assign ARRAY_WORD = out_word_reg;
  assign BUSY_FLAG = busy_reg;
  assign WRITE_LATCH_FLAG = latch_reg;
  assign FOUR_WIRE_CMD_MODE = four_wire_reg;
endmodule

// file: tb/sfp_cmd_seq_chk.sv
`timescale 1ns/1ps
module sfp_cmd_seq_chk (
  input wire logic CLOCK,
  input wire logic RESET_N,
  input wire logic CS_N,
  input wire sfp_pkg::sfp_array_word_type ARRAY_WORD,
  input wire logic ARRAY_VALID,
  input wire logic ARRAY_READY,
  input wire logic BUSY_FLAG,
  input wire logic WRITE_LATCH_FLAG,
  input wire logic FOUR_WIRE_CMD_MODE
);
  import sfp_pkg::*;
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RESET_N);

  // Steps of a self-timed cycle and of the page walk
  sequence cycle_start;
    $rose(BUSY_FLAG);
  endsequence
  sequence prog_taken;
    ARRAY_VALID && ARRAY_READY && ARRAY_WORD.op == ARR_PROGRAM;
  endsequence
  sequence prog_next;
    ARRAY_VALID && ARRAY_WORD.op == ARR_PROGRAM;
  endsequence

  a_latch_clear: assert property (cycle_start |-> ##[0:2] !WRITE_LATCH_FLAG)
    else $error("write latch still set after cycle start");
  a_start_on_select: assert property (cycle_start |-> CS_N && $past(CS_N, 3))
    else $error("cycle started with select low");
  a_busy_hold: assert property (cycle_start |-> BUSY_FLAG [*8])
    else $error("busy dropped too early");
  a_word_stands: assert property (ARRAY_VALID && !ARRAY_READY
    |=> ARRAY_VALID && $stable(ARRAY_WORD))
    else $error("array word changed while stalled");
  a_valid_busy: assert property (ARRAY_VALID |-> BUSY_FLAG)
    else $error("array word outside a cycle");
  a_wipe_word: assert property (ARRAY_VALID && ARRAY_WORD.op == ARR_WIPE
    |-> ARRAY_WORD.data == ERASED_BYTE && ARRAY_WORD.addr[11:0] == 12'h000)
    else $error("wipe word not aligned or not erased value");
  a_page_ascend: assert property (prog_taken ##1 prog_next
    |-> ARRAY_WORD.addr[31:8] == $past(ARRAY_WORD.addr[31:8])
    && ARRAY_WORD.addr[7:0] > $past(ARRAY_WORD.addr[7:0]))
    else $error("program walk left page or not ascending");
  a_mode_sticky: assert property (FOUR_WIRE_CMD_MODE |=> FOUR_WIRE_CMD_MODE)
    else $error("four-wire mode dropped");
endmodule

bind sfp_cmd_seq sfp_cmd_seq_chk i_chk (.CLOCK(CLOCK), .RESET_N(RESET_N), .CS_N(CS_N),
  .ARRAY_WORD(ARRAY_WORD), .ARRAY_VALID(ARRAY_VALID), .ARRAY_READY(ARRAY_READY),
  .BUSY_FLAG(BUSY_FLAG), .WRITE_LATCH_FLAG(WRITE_LATCH_FLAG),
  .FOUR_WIRE_CMD_MODE(FOUR_WIRE_CMD_MODE));

// file: tb/sfp_host_model.sv
`timescale 1ns/1ps
module sfp_host_model (
  input wire logic clk,
  output logic sclk,
  output logic cs_n,
  output logic [3:0] io
);
  // Idle: clock low, select high, lanes parked
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    io = 4'h5;
  end
  // Half serial period; data moves mid-phase so it is settled around the edge
  task automatic half(input logic [3:0] val);
    repeat (4) @(negedge clk);
    io <= val;
    repeat (4) @(negedge clk);
    sclk <= ~sclk;
  endtask
  // One byte MSB first, w bits per edge; ddr samples on both edges
  task automatic put_byte(input logic [7:0] b, input int w, input bit ddr);
    logic [7:0] s;
    for (int e = 0; e < 8 / w; e++) begin
      s = b << (w * e);
      half(4'(s >> (8 - w)));
      if (!ddr) half(~io);
    end
  endtask
  // Select held low for the whole frame
  task automatic frame_start();
    @(negedge clk);
    cs_n <= 1'b0;
    repeat (8) @(negedge clk);
  endtask
  // Lanes released: show the inverse so stale data cannot pass
  task automatic frame_end();
    repeat (8) @(negedge clk);
    cs_n <= 1'b1;
    io <= ~io;
    repeat (8) @(negedge clk);
  endtask
endmodule

// file: tb/test_serial_flash_program_erase_cmds.sv
`timescale 1ns/1ps
module test_serial_flash_program_erase_cmds;
  import sfp_pkg::*;
  localparam int unsigned PCYC = 300;
  localparam int unsigned WCYC = 20;
  localparam int LIMIT = 60000;
  logic clock, reset_n, sclk, cs_n, quad_on, four_byte, ready, busy, latch, fw_mode, valid;
  logic stall, hold_low;
  logic [3:0] io;
  logic [7:0] ext_addr;
  sfp_protect_type protect;
  sfp_array_word_type word;
  sfp_array_word_type got[$];
  int fail_count, n_compared, cyc;

  sfp_host_model i_host (.clk(clock), .sclk(sclk), .cs_n(cs_n), .io(io));
  sfp_cmd_seq #(.PROGRAM_CYCLES(PCYC), .WIPE_CYCLES(WCYC), .FIFO_DEPTH(4)) i_dut (
    .CLOCK(clock), .RESET_N(reset_n), .SCLK(sclk), .CS_N(cs_n),
    .IO_LANE_0(io[0]), .IO_LANE_1(io[1]), .IO_LANE_2(io[2]), .IO_LANE_3(io[3]),
    .QUAD_PINS_ON(quad_on), .FOUR_BYTE_MODE(four_byte), .EXT_ADDR(ext_addr),
    .PROTECT(protect), .ARRAY_WORD(word), .ARRAY_VALID(valid), .ARRAY_READY(ready),
    .BUSY_FLAG(busy), .WRITE_LATCH_FLAG(latch), .FOUR_WIRE_CMD_MODE(fw_mode));

  always #12.5 clock = ~clock;
  // Far-side sink: may stall every other cycle or hold off entirely
  always @(negedge clock) ready <= hold_low ? 1'b0 : (stall ? ~ready : 1'b1);
  always @(posedge clock) begin
    if (valid && ready) got.push_back(word);
    cyc++;
    if (cyc == LIMIT) begin
      fail_count++;
      $display("MISMATCH t=%0t timeout", $time);
      complete_run();
    end
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] expv, input string what);
    n_compared++;
    if (seen !== expv) begin
      fail_count++;
      $display("MISMATCH t=%0t %s seen %0h expected %0h", $time, what, seen, expv);
    end
  endtask

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  function automatic logic [7:0] dbyte(input int n);
    return 8'(n) ^ 8'h5A;
  endfunction

  // Whole frame; quad program moves address and data on four lanes
  task automatic send(input logic [7:0] op, input logic [31:0] a, input int na,
                      input int nd, input int w, input bit ddr);
    int qw;
    qw = (op == OP_QUAD_PAGE_WRITE_4B) ? 4 : w;
    i_host.frame_start();
    i_host.put_byte(op, w, 1'b0);
    for (int i = na - 1; i >= 0; i--) i_host.put_byte(a[8*i +: 8], qw, ddr);
    for (int n = 0; n < nd; n++) i_host.put_byte(dbyte(n), qw, ddr);
    i_host.frame_end();
  endtask

  task automatic unlock(input int w);
    send(OP_WRITE_UNLOCK, 32'h0, 0, 0, w, 1'b0);
  endtask

  task automatic wait_idle();
    int t;
    t = 0;
    while (busy !== 1'b0 && t < 4000) begin
      @(negedge clock);
      t++;
    end
    check(t < 4000, 1, "busy ends");
    repeat (8) @(negedge clock);
  endtask

  // Expected page walk: last byte per column wins, ascending columns only
  task automatic check_prog(input logic [31:0] a, input int nd);
    logic [7:0] d[256];
    bit wr[256];
    int k, col;
    k = 0;
    for (int c = 0; c < 256; c++) wr[c] = 1'b0;
    for (int n = 0; n < nd; n++) begin
      col = (int'(a[7:0]) + n) % 256;
      d[col] = dbyte(n);
      wr[col] = 1'b1;
    end
    for (int c = 0; c < 256; c++) if (wr[c]) begin
      check(k < got.size() ? got[k] : '0, {ARR_PROGRAM, a[31:8], 8'(c), d[c]}, "pword");
      k++;
    end
    check(got.size(), k, "program count");
    got.delete();
  endtask

  task automatic do_reset();
    @(negedge clock);
    reset_n <= 1'b0;
    repeat (16) @(negedge clock);
    reset_n <= 1'b1;
    repeat (8) @(negedge clock);
  endtask

  task automatic t_wipe();
    unlock(1);
    check(latch, 1, "latch set");
    send(OP_BLOCK4K_WIPE, 32'h00123456, 3, 0, 1, 1'b0);
    check(busy, 1, "wipe busy");
    check(latch, 0, "latch cleared");
    wait_idle();
    check(got.size(), 1, "wipe count");
    check(got.size() > 0 ? 41'(got[0]) : 41'h0, {ARR_WIPE, 32'h02123000, ERASED_BYTE}, "wipe");
    got.delete();
    send(OP_BLOCK4K_WIPE, 32'h00123456, 3, 0, 1, 1'b0);
    check(busy, 0, "wipe without latch");
  endtask

  task automatic t_refuse();
    unlock(1);
    send(OP_BLOCK4K_WIPE, 32'h00123456, 4, 0, 1, 1'b0);
    check(busy, 0, "wipe extra byte");
    protect <= '{1'b0, 1'b0, 4'hB};
    send(OP_BLOCK4K_WIPE, 32'h00123456, 3, 0, 1, 1'b0);
    check(busy, 0, "protected wipe");
    send(OP_DOUBLE_RATE_PROGRAM, 32'h00123400, 3, 1, 1, 1'b1);
    check(busy, 0, "protected program");
    check({latch, 8'(got.size())}, 9'h100, "silent refusal");
    protect <= '0;
    send(OP_DOUBLE_RATE_PROGRAM, 32'h00123400, 3, 0, 1, 1'b1);
    check(busy, 0, "program without data");
  endtask

  task automatic t_ddr();
    four_byte <= 1'b1;
    unlock(1);
    send(OP_DOUBLE_RATE_PROGRAM, 32'h000201FE, 4, 3, 1, 1'b1);
    check({busy, latch}, 2'b10, "program start");
    wait_idle();
    check_prog(32'h000201FE, 3);
  endtask

  task automatic t_quad();
    four_byte <= 1'b0;
    quad_on <= 1'b0;
    stall <= 1'b1;
    unlock(1);
    send(OP_QUAD_PAGE_WRITE_4B, 32'h00ABCD10, 4, 1, 1, 1'b0);
    check(busy, 0, "quad pins off");
    quad_on <= 1'b1;
    send(OP_QUAD_PAGE_WRITE_4B, 32'h00ABCD10, 4, 258, 1, 1'b0);
    wait_idle();
    check_prog(32'h00ABCD10, 258);
    send(OP_QUAD_PAGE_WRITE_4B, 32'h00ABCD10, 4, 1, 1, 1'b0);
    check(busy, 0, "quad without latch");
    stall <= 1'b0;
  endtask

  task automatic t_busy();
    hold_low <= 1'b1;
    unlock(1);
    send(OP_DOUBLE_RATE_PROGRAM, 32'h000300F0, 3, 8, 1, 1'b1);
    unlock(1);
    check(latch, 1, "unlock while busy");
    send(OP_BLOCK4K_WIPE, 32'h00123456, 3, 0, 1, 1'b0);
    check({busy, valid}, 2'b11, "walk held");
    hold_low <= 1'b0;
    wait_idle();
    check_prog(32'h020300F0, 8);
  endtask

  task automatic t_four();
    send(OP_FOUR_WIRE_ENTRY, 32'h0, 0, 0, 1, 1'b0);
    check(fw_mode, 1, "four-wire on");
    unlock(4);
    send(OP_BLOCK4K_WIPE, 32'h00654321, 3, 0, 4, 1'b0);
    check(busy, 1, "four-wire wipe busy");
    wait_idle();
    check(got.size() > 0 ? 41'(got[0]) : 41'h0, {ARR_WIPE, 32'h02654000, ERASED_BYTE}, "fw");
    got.delete();
    do_reset();
    check({fw_mode, latch, busy, valid}, 4'h0, "reset state");
  endtask

  initial begin
    clock = 1'b0;
    reset_n = 1'b0;
    quad_on = 1'b1;
    four_byte = 1'b0;
    ext_addr = 8'h02;
    protect = '0;
    ready = 1'b1;
    stall = 1'b0;
    hold_low = 1'b0;
    do_reset();
    t_wipe();
    t_refuse();
    t_ddr();
    t_quad();
    t_busy();
    t_four();
    complete_run();
  end
endmodule
